//--- hdl/sld_supply_level_detect_control.sv
`timescale 1ns/10ps
module sld_supply_level_detect_control (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [sld_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    input wire logic [sld_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_supply_below,
    output logic [sld_pkg::DATA_W-1:0] o_rdata,
    output logic o_detect_enable,
    output sld_pkg::sld_sel_t o_detect_threshold
);
    import sld_pkg::*;

    logic enable;
    sld_sel_t select;
    logic [DATA_W-1:0] rdata;
    logic next_enable;
    sld_sel_t next_select;
    logic [DATA_W-1:0] next_rdata;
    logic hit;
    logic [DATA_W-1:0] reg_view;
    logic wr_hit;
    logic rd_hit;
    logic wr_enable;
    sld_sel_t wr_select;
    logic shadow_enable;
    sld_sel_t shadow_select;
    logic next_shadow_enable;
    sld_sel_t next_shadow_select;
    logic [DATA_W-1:0] expect_rdata;
    logic [DATA_W-1:0] next_expect_rdata;

    sld_flag_if flag_bus ();

    assign flag_bus.enable = enable;
    assign flag_bus.supply_below = i_supply_below;

    sld_flag_track u_flag_track (
        .i_clock (i_clock),
        .i_rst (i_rst),
        .bus (flag_bus)
    );

    assign hit = (i_addr == ADDR_LEVEL_DETECT_CONTROL);
    assign wr_hit = i_wr_en & hit;
    assign rd_hit = i_rd_en & hit;
    assign wr_enable = i_wdata[BIT_ENABLE];
    assign wr_select = i_wdata[SEL_MSB:SEL_LSB];

    // control register write path; the select reaches the reference unqualified
    always_comb begin
        next_enable = enable;
        next_select = select;
        if (wr_hit) begin
            next_enable = wr_enable;
            next_select = wr_select;
            // upper bits and the flag bit are not stored
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            enable <= RESET_ENABLE;
            select <= RESET_SELECT;
        end else begin
            enable <= next_enable;
            select <= next_select;
        end
    end

    // register image as software sees it
    always_comb begin
        reg_view = '0;
        reg_view[BIT_ENABLE] = enable;
        reg_view[BIT_FLAG] = flag_bus.flag;
        reg_view[SEL_MSB:SEL_LSB] = select;
    end

    // read data held until the next read; unmapped reads give zero
    always_comb begin
        next_rdata = rdata;
        if (i_rd_en) begin
            next_rdata = hit ? reg_view : '0;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rdata <= RESET_RDATA;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign o_rdata = rdata;
    assign o_detect_enable = enable;
    assign o_detect_threshold = select;

    // assertion-only copy of the last control write, decoded apart from the real path
    always_comb begin
        next_shadow_enable = shadow_enable;
        next_shadow_select = shadow_select;
        if (i_wr_en && (i_addr == ADDR_LEVEL_DETECT_CONTROL)) begin
            next_shadow_enable = i_wdata[BIT_ENABLE];
            next_shadow_select = i_wdata[SEL_MSB:SEL_LSB];
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            shadow_enable <= RESET_ENABLE;
            shadow_select <= RESET_SELECT;
        end else begin
            shadow_enable <= next_shadow_enable;
            shadow_select <= next_shadow_select;
        end
    end

    // expected read image built from the copy, for the read-path check
    always_comb begin
        next_expect_rdata = expect_rdata;
        if (i_rd_en) begin
            next_expect_rdata = '0;
            if (i_addr == ADDR_LEVEL_DETECT_CONTROL) begin
                next_expect_rdata[BIT_ENABLE] = shadow_enable;
                next_expect_rdata[BIT_FLAG] = flag_bus.flag;
                next_expect_rdata[SEL_MSB:SEL_LSB] = shadow_select;
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            expect_rdata <= RESET_RDATA;
        end else begin
            expect_rdata <= next_expect_rdata;
        end
    end

    AST_ENABLE_WRITE: assert property (@(posedge i_clock) disable iff (i_rst)
        i_wr_en && hit |=> o_detect_enable == $past(i_wdata[BIT_ENABLE]))
        else $error("enable bit not taken from write");
    AST_SELECT_WRITE: assert property (@(posedge i_clock) disable iff (i_rst)
        i_wr_en && hit |=> o_detect_threshold == $past(i_wdata[SEL_MSB:SEL_LSB]))
        else $error("threshold select not taken from write");
    AST_SELECT_HOLDS: assert property (@(posedge i_clock) disable iff (i_rst)
        !(i_wr_en && hit) |=> $stable(o_detect_threshold) && $stable(o_detect_enable))
        else $error("control changed without a write");
    AST_RESET_VALUES: assert property (@(posedge i_clock)
        $fell(i_rst) |-> o_detect_threshold == RESET_SELECT && !o_detect_enable)
        else $error("control not at reset value after reset");
    AST_RESERVED_ZERO: assert property (@(posedge i_clock) disable iff (i_rst)
        o_rdata[DATA_W-1:SEL_MSB+1] == '0)
        else $error("reserved bits read nonzero");
    AST_READ_IMAGE: assert property (@(posedge i_clock) disable iff (i_rst)
        i_rd_en && hit && !(i_wr_en) |=> o_rdata[SEL_MSB:SEL_LSB] == $past(select)
            && o_rdata[BIT_FLAG] == $past(flag_bus.flag) && o_rdata[BIT_ENABLE] == $past(enable))
        else $error("read image wrong");
    AST_FLAG_LOW_OFF: assert property (@(posedge i_clock) disable iff (i_rst)
        !o_detect_enable ##1 !o_detect_enable && i_rd_en && hit |=> !o_rdata[BIT_FLAG])
        else $error("flag read high while detector off");
    AST_FLAG_TRACKS: assert property (@(posedge i_clock) disable iff (i_rst)
        o_detect_enable && i_supply_below ##1 i_rd_en && hit |=> o_rdata[BIT_FLAG])
        else $error("flag not read high while below");
    AST_UNMAPPED_ZERO: assert property (@(posedge i_clock) disable iff (i_rst)
        i_rd_en && !hit |=> o_rdata == '0)
        else $error("unmapped read not zero");

    AST_ENABLE_MATCHES_LAST: assert property (@(posedge i_clock) disable iff (i_rst)
        o_detect_enable == shadow_enable)
        else $error("enable differs from last written value");
    AST_SELECT_MATCHES_LAST: assert property (@(posedge i_clock) disable iff (i_rst)
        o_detect_threshold == shadow_select)
        else $error("threshold differs from last written select");
    AST_ENABLE_ONLY_ON_WRITE: assert property (@(posedge i_clock) disable iff (i_rst)
        $changed(o_detect_enable) |-> $past(wr_hit))
        else $error("enable changed without a control write");
    AST_SELECT_ONLY_ON_WRITE: assert property (@(posedge i_clock) disable iff (i_rst)
        $changed(o_detect_threshold) |-> $past(wr_hit))
        else $error("threshold changed without a control write");
    AST_FOREIGN_WRITE_IGNORED: assert property (@(posedge i_clock) disable iff (i_rst)
        i_wr_en && !hit |=> $stable(o_detect_enable) && $stable(o_detect_threshold))
        else $error("write to another address changed control");

    AST_READ_DURING_WRITE: assert property (@(posedge i_clock) disable iff (i_rst)
        rd_hit && i_wr_en |=> o_rdata[SEL_MSB:SEL_LSB] == $past(o_detect_threshold)
            && o_rdata[BIT_ENABLE] == $past(o_detect_enable))
        else $error("read beside a write did not return the old image");
    AST_RDATA_STANDS: assert property (@(posedge i_clock) disable iff (i_rst)
        $changed(o_rdata) |-> $past(i_rd_en))
        else $error("read data changed without a read");
    AST_RDATA_MATCHES_COPY: assert property (@(posedge i_clock) disable iff (i_rst)
        o_rdata == expect_rdata)
        else $error("read data differs from expected image");
    AST_RESET_READ_ZERO: assert property (@(posedge i_clock)
        $fell(i_rst) |-> o_rdata == RESET_RDATA && !flag_bus.flag)
        else $error("read data or flag not cleared by reset");

    AST_FLAG_FROM_PAST: assert property (@(posedge i_clock) disable iff (i_rst)
        flag_bus.flag == $past(o_detect_enable && i_supply_below))
        else $error("flag does not follow enabled comparator");
    AST_FLAG_CLEAR_READ: assert property (@(posedge i_clock) disable iff (i_rst)
        o_detect_enable && !i_supply_below ##1 rd_hit |=> !o_rdata[BIT_FLAG])
        else $error("flag read high while above threshold");
    AST_FLAG_IGNORES_WRITE: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_hit && !o_detect_enable |=> !flag_bus.flag)
        else $error("flag taken from a write");
    AST_FLAG_OFF_AFTER_DISABLE: assert property (@(posedge i_clock) disable iff (i_rst)
        wr_hit && !wr_enable |=> ##1 !flag_bus.flag)
        else $error("flag still set after detector was switched off");
    AST_FLAG_OFF_IDLE: assert property (@(posedge i_clock) disable iff (i_rst)
        !o_detect_enable |=> !flag_bus.flag)
        else $error("flag set while detector off");

    COV_ENABLE_HIGHEST: cover property (@(posedge i_clock) disable iff (i_rst)
        i_wr_en && hit && i_wdata[BIT_ENABLE] && i_wdata[SEL_MSB:SEL_LSB] == SEL_3V9);
    COV_FLAG_SET_READ: cover property (@(posedge i_clock) disable iff (i_rst)
        i_rd_en && hit ##1 o_rdata[BIT_FLAG]);
    COV_FLAG_CLEARS: cover property (@(posedge i_clock) disable iff (i_rst)
        flag_bus.flag ##1 !flag_bus.flag);
    COV_DISABLE: cover property (@(posedge i_clock) disable iff (i_rst)
        o_detect_enable ##1 !o_detect_enable);
    COV_READ_WITH_WRITE: cover property (@(posedge i_clock) disable iff (i_rst)
        rd_hit && wr_hit);
endmodule

//--- shared/sld_pkg.sv
// Behaviour
// - control bit 0 switches detection on/off
// - bits 3:2 select 2.4/2.7/3.3/3.9 V threshold
// - bit 1 is read-only below-threshold flag
// - threshold follows last written select code directly
// - reset select value resolved to table value 00
// - flag tracks comparator while detection enabled
package sld_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int SEL_W = 2;
    localparam logic [ADDR_W-1:0] ADDR_LEVEL_DETECT_CONTROL = 8'hFB;
    localparam int BIT_ENABLE = 0;
    localparam int BIT_FLAG = 1;
    localparam int SEL_LSB = 2;
    localparam int SEL_MSB = 3;
    localparam logic RESET_ENABLE = 1'b0;
    localparam logic RESET_FLAG = 1'b0;
    localparam logic [SEL_W-1:0] RESET_SELECT = 2'h0;
    localparam logic [DATA_W-1:0] RESET_RDATA = 8'h00;
    localparam logic [SEL_W-1:0] SEL_2V4 = 2'h0;
    localparam logic [SEL_W-1:0] SEL_2V7 = 2'h1;
    localparam logic [SEL_W-1:0] SEL_3V3 = 2'h2;
    localparam logic [SEL_W-1:0] SEL_3V9 = 2'h3;
    typedef logic [SEL_W-1:0] sld_sel_t;
endpackage

//--- shared/sld_flag_if.sv
`timescale 1ns/10ps
interface sld_flag_if;
    logic enable;
    logic supply_below;
    logic flag;
    modport ctrl (output enable, output supply_below, input flag);
    modport track (input enable, input supply_below, output flag);
endinterface

//--- hdl/sld_flag_track.sv
`timescale 1ns/10ps
module sld_flag_track (
    input wire logic i_clock,
    input wire logic i_rst,
    sld_flag_if.track bus
);
    import sld_pkg::*;

    logic flag;
    logic next_flag;

    // flag is forced low while the detector is off
    always_comb begin
        next_flag = bus.enable & bus.supply_below;
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            flag <= RESET_FLAG;
        end else begin
            flag <= next_flag;
        end
    end

    assign bus.flag = flag;

    AST_FLAG_FOLLOWS_BELOW: assert property (@(posedge i_clock) disable iff (i_rst)
        bus.enable && bus.supply_below |=> flag)
        else $error("flag not set while enabled and below");
    AST_FLAG_CLEARS_ABOVE: assert property (@(posedge i_clock) disable iff (i_rst)
        !bus.supply_below |=> !flag)
        else $error("flag not cleared while above threshold");
    AST_FLAG_ONLY_ENABLED: assert property (@(posedge i_clock) disable iff (i_rst)
        flag |-> $past(bus.enable))
        else $error("flag set while detector was off");
endmodule

//--- verif/test_sld_supply_level_detect_control.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end

module test_sld_supply_level_detect_control;
    import sld_pkg::*;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [ADDR_W-1:0] i_addr = 8'h00;
    logic i_wr_en = 1'b0;
    logic i_rd_en = 1'b0;
    logic [DATA_W-1:0] i_wdata = 8'h00;
    logic i_supply_below = 1'b0;
    logic [DATA_W-1:0] o_rdata;
    logic o_detect_enable;
    sld_sel_t o_detect_threshold;
    logic [7:0] d;
    logic [7:0] a;
    int errors = 0;
    int checks_done = 0;
    int seed = 25;
    int m_en = 0;
    int m_sel = 0;
    int img;
    int exp_q[$];

    sld_supply_level_detect_control dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
        .i_wdata(i_wdata), .i_supply_below(i_supply_below), .o_rdata(o_rdata),
        .o_detect_enable(o_detect_enable), .o_detect_threshold(o_detect_threshold)
    );

    initial begin
        forever #5 i_clock = ~i_clock;
    end

    // model image: flag only while enabled, upper bits zero
    function int image(input logic [7:0] ad);
        if (ad != ADDR_LEVEL_DETECT_CONTROL) return 0;
        return m_sel * 4 + (m_en & int'(i_supply_below)) * 2 + m_en;
    endfunction

    task wr(input logic [7:0] ad, input logic [7:0] dd);
        i_addr = ad;
        i_wdata = dd;
        i_wr_en = 1'b1;
        @(negedge i_clock);
        i_wr_en = 1'b0;
        if (ad == ADDR_LEVEL_DETECT_CONTROL) begin
            m_en = dd[0];
            m_sel = dd[3:2];
        end
        `CHK(o_detect_enable, m_en[0])
        `CHK(o_detect_threshold, sld_sel_t'(m_sel))
        repeat (2) @(negedge i_clock);
    endtask

    task rd(input logic [7:0] ad);
        exp_q.push_back(image(ad));
        i_addr = ad;
        i_rd_en = 1'b1;
        @(negedge i_clock);
        i_rd_en = 1'b0;
        img = exp_q.pop_front();
        `CHK(o_rdata, img[7:0])
    endtask

    task complete_run;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        errors++;
        complete_run;
    end

    initial begin
        repeat (3) @(negedge i_clock);
        i_rst = 1'b0;
        `CHK(o_detect_threshold, SEL_2V4)
        `CHK(o_detect_enable, RESET_ENABLE)
        `CHK(o_rdata, RESET_RDATA)
        rd(ADDR_LEVEL_DETECT_CONTROL);
        // every select code, both switch states, noisy reserved bits
        for (int k = 0; k < 8; k++) begin
            i_supply_below = 1'($random(seed));
            d = 8'($random(seed));
            d[3:2] = 2'(k);
            d[0] = k[2];
            wr(ADDR_LEVEL_DETECT_CONTROL, d);
            rd(ADDR_LEVEL_DETECT_CONTROL);
        end
        // detector left on: flag follows the comparator with no write
        for (int k = 0; k < 6; k++) begin
            i_supply_below = 1'($random(seed));
            @(negedge i_clock);
            rd(ADDR_LEVEL_DETECT_CONTROL);
        end
        for (int k = 0; k < 30; k++) begin
            a = ($random(seed) & 1) ? ADDR_LEVEL_DETECT_CONTROL : 8'($random(seed));
            i_supply_below = 1'($random(seed));
            wr(a, 8'($random(seed)));
            rd(a);
        end
        // read and write together: read sees old image
        @(negedge i_clock);
        img = image(ADDR_LEVEL_DETECT_CONTROL);
        i_addr = ADDR_LEVEL_DETECT_CONTROL;
        i_wdata = ~o_rdata;
        i_wr_en = 1'b1;
        i_rd_en = 1'b1;
        @(negedge i_clock);
        {i_wr_en, i_rd_en} = 2'b00;
        `CHK(o_rdata, img[7:0])
        m_en = i_wdata[0];
        m_sel = i_wdata[3:2];
        `CHK(o_detect_enable, m_en[0])
        `CHK(o_detect_threshold, sld_sel_t'(m_sel))
        // reset in mid-run
        i_rst = 1'b1;
        @(negedge i_clock);
        i_rst = 1'b0;
        m_en = 0;
        m_sel = 0;
        `CHK(o_detect_enable, RESET_ENABLE)
        `CHK(o_detect_threshold, SEL_2V4)
        rd(ADDR_LEVEL_DETECT_CONTROL);
        complete_run;
    end
endmodule
